// *** rtl/clock_gen_pin_control_defs.vh ***
// Constants for the clock generator pin control block.
// Assumes inclusion by bare name from rtl/.
`ifndef CLOCK_GEN_PIN_CONTROL_DEFS_VH
`define CLOCK_GEN_PIN_CONTROL_DEFS_VH

`define CGP_NUM_SYNTH          2
`define CGP_NUM_INT_DIV        5
`define CGP_NUM_OUT            12
`define CGP_NUM_BANK           6
`define CGP_DIV_MIN            8'h08
`define CGP_DIV_MAX            8'hff
`define CGP_SPREAD_MIN_TENTHS  5'h01
`define CGP_SPREAD_MAX_TENTHS  5'h19
`define CGP_SPREAD_MAX_FREQ_MHZ 250
`define CGP_I2C_ADDR_DEFAULT   7'h6a
`define CGP_OE_OFF_MIN_CYC     2
`define CGP_OE_OFF_MAX_CYC     6
`define CGP_OE_ON_TIME_NS      20000
`define CGP_CLK_PERIOD_NS      10
`define CGP_OE_ON_CYC          ((`CGP_OE_ON_TIME_NS / `CGP_CLK_PERIOD_NS) - 1)
`define CGP_SRC_XTAL           2'h0
`define CGP_SRC_CLKIN_TWO      2'h1
`define CGP_SRC_CLKIN_THREE    2'h2
`define CGP_OE_SCOPE_SINGLE    2'h0
`define CGP_OE_SCOPE_BANK      2'h1
`define CGP_OE_SCOPE_GLOBAL    2'h2

`endif

// *** rtl/output_gate.v ***
// One output's glitch-free enable gate.
// Assumes a divided output clock level sampled in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_pin_control_defs.vh"

module output_gate #(
  parameter ON_CYC = 1999
) (
  // Clock and reset
  input  wire        i_clk_sys,
  input  wire        i_rst_n,
  // Control
  input  wire        i_want_on,
  input  wire        i_out_clk,
  // Status
  output reg         o_drive,
  output reg         o_gated_clk
);

  localparam [2:0] ST_OFF   = 3'h1;
  localparam [2:0] ST_WAKE  = 3'h2;
  localparam [2:0] ST_ON    = 3'h4;

  reg [2:0]  state;
  reg [15:0] wait_cnt;
  reg        prev_clk;
  wire       fall = prev_clk & ~i_out_clk;

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state       <= ST_OFF;
      wait_cnt    <= 16'h0000;
      prev_clk    <= 1'b0;
      o_drive     <= 1'b0;
      o_gated_clk <= 1'b0;
    end else begin
      prev_clk    <= i_out_clk;
      o_gated_clk <= o_drive & i_out_clk;
      case (state)
        ST_OFF: begin
          wait_cnt <= 16'h0000;
          if (i_want_on) begin
            state <= ST_WAKE;
          end
        end
        ST_WAKE: begin
          // Wake counts to ON_CYC, then waits for a low phase before drive starts
          if (!i_want_on) begin
            state <= ST_OFF;
          end else if (wait_cnt >= ON_CYC[15:0] && !i_out_clk) begin
            state   <= ST_ON;
            o_drive <= 1'b1;
          end else if (wait_cnt < ON_CYC[15:0]) begin
            wait_cnt <= wait_cnt + 16'h0001;
          end
        end
        ST_ON: begin
          // Stop only after the running period ends, so no runt pulse
          if (!i_want_on && fall) begin
            state   <= ST_OFF;
            o_drive <= 1'b0;
          end
        end
        default: begin
          state   <= ST_OFF;
          o_drive <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** rtl/clock_gen_pin_control.v ***
// Pin control logic of a multi-output clock generator.
// Assumes register values come from an I2C target outside, and that
// output clocks arrive as levels slow against the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "clock_gen_pin_control_defs.vh"

module clock_gen_pin_control #(
  parameter NUM_SYNTH    = `CGP_NUM_SYNTH,
  parameter NUM_INT_DIV  = `CGP_NUM_INT_DIV,
  parameter NUM_OUT      = `CGP_NUM_OUT,
  parameter NUM_BANK     = `CGP_NUM_BANK,
  parameter PROFILE_BITS = 2,
  parameter OE_ON_CYC    = `CGP_OE_ON_CYC
) (
  // Clock and reset
  input  wire                        i_clk_sys,
  input  wire                        i_rst_n,
  // Hardware pins
  input  wire                        i_spread_enable_pin_synth_zero,
  input  wire                        i_spread_enable_pin_synth_one,
  input  wire [NUM_INT_DIV-1:0]      i_integer_divider_freq_select,
  input  wire [NUM_SYNTH-1:0]        i_fractional_freq_profile_select,
  input  wire                        i_output_enable_low_pin,
  input  wire                        i_addr_select_pin,
  input  wire [1:0]                  i_input_source_select,
  input  wire [PROFILE_BITS-1:0]     i_profile_select,
  // Pin assignment
  input  wire [NUM_SYNTH-1:0]        i_spread_pin_assigned,
  input  wire [NUM_INT_DIV-1:0]      i_int_sel_pin_assigned,
  input  wire [NUM_SYNTH-1:0]        i_frac_sel_pin_assigned,
  input  wire                        i_oe_pin_assigned,
  input  wire [1:0]                  i_oe_pin_scope,
  input  wire [3:0]                  i_oe_pin_target,
  input  wire [NUM_OUT-1:0]          i_out_bank_map_lsb,
  input  wire [NUM_OUT-1:0]          i_out_bank_map_mid,
  input  wire [NUM_OUT-1:0]          i_out_bank_map_msb,
  input  wire [NUM_OUT-1:0]          i_out_from_synth,
  input  wire [NUM_OUT-1:0]          i_out_synth_index,
  input  wire [NUM_OUT-1:0]          i_out_cmos_pair,
  // Register controls
  input  wire [NUM_SYNTH-1:0]        i_reg_spread_enable,
  input  wire [NUM_SYNTH-1:0]        i_reg_spread_center,
  input  wire [5*NUM_SYNTH-1:0]      i_reg_spread_a_tenths,
  input  wire [5*NUM_SYNTH-1:0]      i_reg_spread_b_tenths,
  input  wire [NUM_INT_DIV-1:0]      i_reg_int_select,
  input  wire [8*NUM_INT_DIV-1:0]    i_reg_int_div_a,
  input  wire [8*NUM_INT_DIV-1:0]    i_reg_int_div_b,
  input  wire [NUM_SYNTH-1:0]        i_reg_frac_select,
  input  wire [NUM_OUT-1:0]          i_reg_out_enable,
  input  wire [1:0]                  i_reg_source_select,
  input  wire                        i_factory_programmed,
  input  wire                        i_cfg_loaded,
  input  wire [NUM_OUT-1:0]          i_out_clk,
  // Status and controls out
  output reg  [NUM_SYNTH-1:0]        o_synth_spread_on,
  output reg  [NUM_SYNTH-1:0]        o_synth_spread_center,
  output reg  [5*NUM_SYNTH-1:0]      o_synth_spread_tenths,
  output reg  [NUM_SYNTH-1:0]        o_synth_profile_b,
  output reg  [8*NUM_INT_DIV-1:0]    o_int_div_value,
  output reg  [NUM_INT_DIV-1:0]      o_int_div_bad,
  output reg  [NUM_OUT-1:0]          o_out_spread,
  output wire [NUM_OUT-1:0]          o_out_drive,
  output wire [NUM_OUT-1:0]          o_out_gated_clk,
  output reg  [6:0]                  o_i2c_address,
  output reg  [1:0]                  o_ref_source,
  output reg  [PROFILE_BITS-1:0]     o_boot_profile,
  output reg                         o_outputs_running
);

  localparam PIN_W = 2 + NUM_INT_DIV + NUM_SYNTH + 1 + 1 + 2 + PROFILE_BITS;
  // Idle levels at reset: the output enable pin reads as disabled
  localparam [PIN_W-1:0] PIN_IDLE = {{(PIN_W-PROFILE_BITS-4){1'b0}}, 1'b1,
                                     {(PROFILE_BITS+3){1'b0}}};

  localparam [4:0] BOOT_RESET  = 5'h01;
  localparam [4:0] BOOT_SETTLE = 5'h02;
  localparam [4:0] BOOT_LOAD   = 5'h04;
  localparam [4:0] BOOT_WAIT   = 5'h08;
  localparam [4:0] BOOT_RUN    = 5'h10;
  // Reset address; its low bit is the strap
  localparam [6:0] ADDR_BASE   = `CGP_I2C_ADDR_DEFAULT;

  // Raw pins gathered so one two-stage synchronizer covers them all
  wire [PIN_W-1:0] pin_raw = {i_spread_enable_pin_synth_one,
                              i_spread_enable_pin_synth_zero,
                              i_integer_divider_freq_select,
                              i_fractional_freq_profile_select,
                              i_output_enable_low_pin,
                              i_addr_select_pin,
                              i_input_source_select,
                              i_profile_select};
  reg  [PIN_W-1:0] pin_meta;
  reg  [PIN_W-1:0] pin_sync;

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_meta <= PIN_IDLE;
      pin_sync <= PIN_IDLE;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  wire [PROFILE_BITS-1:0] s_profile = pin_sync[PROFILE_BITS-1:0];
  wire [1:0]              s_source  = pin_sync[PROFILE_BITS+1:PROFILE_BITS];
  wire                    s_addr    = pin_sync[PROFILE_BITS+2];
  wire                    s_oe_low  = pin_sync[PROFILE_BITS+3];
  wire [NUM_SYNTH-1:0]    s_frac    = pin_sync[PROFILE_BITS+4+NUM_SYNTH-1:PROFILE_BITS+4];
  wire [NUM_INT_DIV-1:0]  s_int     =
    pin_sync[PROFILE_BITS+4+NUM_SYNTH+NUM_INT_DIV-1:PROFILE_BITS+4+NUM_SYNTH];
  wire [1:0]              s_spread  = pin_sync[PIN_W-1:PIN_W-2];

  // Boot sequence: profile caught only once, at load; straps follow live
  reg [4:0] boot_state;

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      boot_state        <= BOOT_RESET;
      o_boot_profile    <= {PROFILE_BITS{1'b0}};
      o_ref_source      <= `CGP_SRC_XTAL;
      o_outputs_running <= 1'b0;
    end else begin
      case (boot_state)
        BOOT_RESET: begin
          boot_state <= BOOT_SETTLE;
        end
        BOOT_SETTLE: begin
          // Both flops must fill before straps can be read
          boot_state <= BOOT_LOAD;
        end
        BOOT_LOAD: begin
          // Synchronizer now holds the live pin levels
          o_boot_profile <= s_profile;
          boot_state     <= BOOT_WAIT;
        end
        BOOT_WAIT: begin
          // Outputs held off until a configuration is in place
          if (i_factory_programmed || i_cfg_loaded) begin
            boot_state        <= BOOT_RUN;
            o_outputs_running <= 1'b1;
          end
        end
        BOOT_RUN: begin
          o_outputs_running <= 1'b1;
        end
        default: begin
          boot_state <= BOOT_RESET;
        end
      endcase
      // Source follows live, not glitch free; board should strap it
      if (boot_state != BOOT_RESET) begin
        o_ref_source <= source_pick(s_source);
      end
    end
  end

  // Address strap follows its pin live, not only at boot
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_i2c_address <= ADDR_BASE;
    end else begin
      o_i2c_address <= {ADDR_BASE[6:1], s_addr};
    end
  end

  // Code 3 hands the choice back to the register
  function [1:0] source_pick;
    input [1:0] pin;
    begin
      if (pin == 2'h3) begin
        source_pick = i_reg_source_select;
      end else begin
        source_pick = pin;
      end
    end
  endfunction

  // Synth spread and profile selection
  integer k;
  reg [NUM_SYNTH-1:0]   next_spread_on;
  reg [NUM_SYNTH-1:0]   next_profile_b;
  reg [5*NUM_SYNTH-1:0] next_tenths;
  reg [4:0]             raw_tenths;

  always @* begin
    next_spread_on = {NUM_SYNTH{1'b0}};
    next_profile_b = {NUM_SYNTH{1'b0}};
    next_tenths    = {5*NUM_SYNTH{1'b0}};
    raw_tenths     = 5'h00;
    for (k = 0; k < NUM_SYNTH; k = k + 1) begin
      next_spread_on[k] = i_spread_pin_assigned[k] ? s_spread[k]
                                                   : i_reg_spread_enable[k];
      next_profile_b[k] = i_frac_sel_pin_assigned[k] ? s_frac[k]
                                                     : i_reg_frac_select[k];
      raw_tenths = next_profile_b[k] ? i_reg_spread_b_tenths[5*k +: 5]
                                     : i_reg_spread_a_tenths[5*k +: 5];
      if (raw_tenths < `CGP_SPREAD_MIN_TENTHS) begin
        next_tenths[5*k +: 5] = `CGP_SPREAD_MIN_TENTHS;
      end else if (raw_tenths > `CGP_SPREAD_MAX_TENTHS) begin
        next_tenths[5*k +: 5] = `CGP_SPREAD_MAX_TENTHS;
      end else begin
        next_tenths[5*k +: 5] = raw_tenths;
      end
    end
  end

  // Integer divider values, out-of-range values refused and flagged
  integer d;
  reg [8*NUM_INT_DIV-1:0] next_div;
  reg [NUM_INT_DIV-1:0]   next_bad;
  reg [7:0]               pick;

  always @* begin
    next_div = {8*NUM_INT_DIV{1'b0}};
    next_bad = {NUM_INT_DIV{1'b0}};
    pick     = 8'h00;
    for (d = 0; d < NUM_INT_DIV; d = d + 1) begin
      pick = ((i_int_sel_pin_assigned[d] ? s_int[d] : i_reg_int_select[d]))
             ? i_reg_int_div_b[8*d +: 8] : i_reg_int_div_a[8*d +: 8];
      next_bad[d] = (pick < `CGP_DIV_MIN);
      next_div[8*d +: 8] = next_bad[d] ? `CGP_DIV_MIN : pick;
    end
  end

  // Immediate, one register stage after the synchronizer
  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_synth_spread_on     <= {NUM_SYNTH{1'b0}};
      o_synth_spread_center <= {NUM_SYNTH{1'b0}};
      o_synth_spread_tenths <= {5*NUM_SYNTH{1'b0}};
      o_synth_profile_b     <= {NUM_SYNTH{1'b0}};
      o_int_div_value       <= {NUM_INT_DIV{`CGP_DIV_MIN}};
      o_int_div_bad         <= {NUM_INT_DIV{1'b0}};
    end else begin
      o_synth_spread_on     <= next_spread_on;
      o_synth_spread_center <= i_reg_spread_center;
      o_synth_spread_tenths <= next_tenths;
      o_synth_profile_b     <= next_profile_b;
      o_int_div_value       <= next_div;
      o_int_div_bad         <= next_bad;
    end
  end

  // Per-output spread and enable decisions
  integer m;
  reg [NUM_OUT-1:0] next_out_spread;
  reg [NUM_OUT-1:0] want_on;
  reg [2:0]         bank_m;
  reg [2:0]         bank_t;
  reg               pin_hit;

  always @* begin
    next_out_spread = {NUM_OUT{1'b0}};
    want_on         = {NUM_OUT{1'b0}};
    bank_m          = 3'h0;
    bank_t          = 3'h0;
    pin_hit         = 1'b0;
    for (m = 0; m < NUM_OUT; m = m + 1) begin
      // Only synth-fed outputs may spread
      next_out_spread[m] = i_out_from_synth[m] &
        o_synth_spread_on[i_out_synth_index[m] ? 1 : 0];
      bank_m  = {i_out_bank_map_msb[m], i_out_bank_map_mid[m], i_out_bank_map_lsb[m]};
      bank_t  = (i_oe_pin_target < NUM_OUT) ?
                {i_out_bank_map_msb[i_oe_pin_target], i_out_bank_map_mid[i_oe_pin_target],
                 i_out_bank_map_lsb[i_oe_pin_target]} : 3'h0;
      case (i_oe_pin_scope)
        `CGP_OE_SCOPE_SINGLE: begin
          // A CMOS pair shares one buffer, so its partner follows
          pin_hit = (i_oe_pin_target == m) ||
                    (i_out_cmos_pair[m] && ((i_oe_pin_target ^ 4'h1) == m));
        end
        `CGP_OE_SCOPE_BANK: begin
          pin_hit = (bank_m == bank_t);
        end
        `CGP_OE_SCOPE_GLOBAL: begin
          pin_hit = 1'b1;
        end
        default: begin
          pin_hit = 1'b0;
        end
      endcase
      if (i_oe_pin_assigned && pin_hit) begin
        want_on[m] = ~s_oe_low & o_outputs_running;
      end else begin
        want_on[m] = i_reg_out_enable[m] & o_outputs_running;
      end
    end
  end

  always @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_out_spread <= {NUM_OUT{1'b0}};
    end else begin
      o_out_spread <= next_out_spread;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g = g + 1) begin : gen_gate
      output_gate #(
        .ON_CYC (OE_ON_CYC)
      ) u_gate (
        .i_clk_sys   (i_clk_sys),
        .i_rst_n     (i_rst_n),
        .i_want_on   (want_on[g]),
        .i_out_clk   (i_out_clk[g]),
        .o_drive     (o_out_drive[g]),
        .o_gated_clk (o_out_gated_clk[g])
      );
    end
  endgenerate

endmodule
`default_nettype wire

// *** testbench/out_clk_source.sv ***
// Output clock source standing in for the dividers behind the gates.
// Assumes a running system clock; output clocks are slow against it.
`timescale 1ns/1ps
`default_nettype none
module out_clk_source #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic        i_clk_sys,
  // Output clocks
  output wire logic [11:0] o_out_clk
);
  logic [3:0]  cnt   = 4'h0;
  logic [11:0] clk_q = 12'h000;
  // Free running, as dividers keep going while gated
  assign o_out_clk = clk_q;
  always @(posedge i_clk_sys) begin
    cnt <= (cnt == 4'(HALF - 1)) ? 4'h0 : cnt + 4'h1;
    if (cnt == 4'(HALF - 1)) begin
      clk_q <= ~clk_q;
    end
  end
endmodule
`default_nettype wire

// *** testbench/clock_gen_pin_control_checker.sv ***
// Assertions on the pin control block ports.
// Assumes default widths and output clocks with 8-cycle half periods.
`timescale 1ns/1ps
`default_nettype none
module clock_gen_pin_control_checker #(
  parameter int OE_ON_CYC = 20
) (
  // Clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  // Pins and controls
  input wire logic        i_spread_enable_pin_synth_zero,
  input wire logic [1:0]  i_spread_pin_assigned,
  input wire logic [4:0]  i_integer_divider_freq_select,
  input wire logic [4:0]  i_int_sel_pin_assigned,
  input wire logic [39:0] i_reg_int_div_a,
  input wire logic [39:0] i_reg_int_div_b,
  input wire logic        i_addr_select_pin,
  input wire logic [1:0]  i_input_source_select,
  input wire logic        i_output_enable_low_pin,
  input wire logic        i_oe_pin_assigned,
  input wire logic [1:0]  i_oe_pin_scope,
  // Outputs
  input wire logic [1:0]  o_synth_spread_on,
  input wire logic [39:0] o_int_div_value,
  input wire logic [4:0]  o_int_div_bad,
  input wire logic [6:0]  o_i2c_address,
  input wire logic [1:0]  o_ref_source,
  input wire logic        o_outputs_running,
  input wire logic [11:0] o_out_drive,
  input wire logic [11:0] o_out_gated_clk
);
  localparam int ON_MAX = OE_ON_CYC + 40;
  // Six output periods plus pin sync
  localparam int OFF_MAX = 110;
  wire [7:0] div0 = i_integer_divider_freq_select[0] ? i_reg_int_div_b[7:0] : i_reg_int_div_a[7:0];
  wire glob = i_oe_pin_assigned && i_oe_pin_scope == 2'h2;
  wire g_on = glob && !i_output_enable_low_pin;
  wire g_off = glob && i_output_enable_low_pin;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  spread_pin_a: assert property (
    (i_spread_pin_assigned[0] && $stable(i_spread_enable_pin_synth_zero))[*4]
    |-> o_synth_spread_on[0] == i_spread_enable_pin_synth_zero)
    else $error("spread state does not follow its pin");
  int_pin_a: assert property (
    (i_int_sel_pin_assigned[0] && $stable({i_integer_divider_freq_select[0],
    i_reg_int_div_a[7:0], i_reg_int_div_b[7:0]}))[*4]
    |-> o_int_div_value[7:0] == ((div0 < 8'h08) ? 8'h08 : div0))
    else $error("divider value does not follow its select pin");
  div_bad_a: assert property (
    o_int_div_bad[2] |-> o_int_div_value[23:16] == 8'h08)
    else $error("bad divide value not replaced");
  addr_lsb_a: assert property (
    $stable(i_addr_select_pin)[*4] |-> o_i2c_address == {6'h35, i_addr_select_pin})
    else $error("address low bit does not follow its pin");
  src_pin_a: assert property (
    (i_input_source_select != 2'h3 && $stable(i_input_source_select))[*4]
    |-> o_ref_source == i_input_source_select)
    else $error("reference source does not follow its pins");
  on_time_a: assert property (
    (g_on && o_outputs_running)[*8] |-> ##[0:ON_MAX] (o_out_drive[0] || !g_on))
    else $error("output not enabled in time");
  off_time_a: assert property (
    g_off[*8] |-> ##[0:OFF_MAX] (!o_out_drive[0] || !g_off))
    else $error("output not disabled in time");
  no_runt_a: assert property (
    $rose(o_out_gated_clk[0]) |-> o_out_gated_clk[0][*6])
    else $error("runt pulse on gated output");
endmodule
`default_nettype wire

bind clock_gen_pin_control clock_gen_pin_control_checker #(.OE_ON_CYC(OE_ON_CYC)) chk_u (
  .i_clk_sys, .i_rst_n, .i_spread_enable_pin_synth_zero, .i_spread_pin_assigned,
  .i_integer_divider_freq_select, .i_int_sel_pin_assigned, .i_reg_int_div_a,
  .i_reg_int_div_b, .i_addr_select_pin, .i_input_source_select,
  .i_output_enable_low_pin, .i_oe_pin_assigned, .i_oe_pin_scope, .o_synth_spread_on,
  .o_int_div_value, .o_int_div_bad, .o_i2c_address, .o_ref_source,
  .o_outputs_running, .o_out_drive, .o_out_gated_clk);

// *** testbench/tb.sv ***
// Self-checking bench for the pin control block.
// Assumes the output clock source and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  logic i_clk_sys, i_rst_n, sp0, sp1, oe_n, adr, oe_as, fact, cfg;
  logic [1:0] fsel, src, prof, sp_as, fr_as, scope, r_sp, r_ctr, r_fs, r_src;
  logic [3:0] tgt;
  logic [4:0] isel, int_as, r_isel;
  logic [9:0] r_ta, r_tb;
  logic [11:0] bank0, from_syn, syn_idx, pair, r_oe;
  logic [39:0] r_da, r_db;
  wire [11:0] oclk, o_spr, drv, gclk;
  wire [1:0] sp_on, sp_ctr, prof_b, rsrc, bprof;
  wire [9:0] sp_t;
  wire [39:0] dv;
  wire [4:0] dbad;
  wire [6:0] i2c;
  wire run;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  logic [19:0] sp_tab [4] = '{20'hd9003, 20'he600c, 20'h35003, 20'h5b00f};
  logic [19:0] oe_tab [7] = '{20'hc1000, 20'hc0fff, 20'hc1000, 20'h89800,
                              20'h88830, 20'ha2807, 20'h00800};

  out_clk_source src_u (.i_clk_sys(i_clk_sys), .o_out_clk(oclk));
  clock_gen_pin_control #(.OE_ON_CYC(20)) dut_u (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_spread_enable_pin_synth_zero(sp0), .i_spread_enable_pin_synth_one(sp1),
    .i_integer_divider_freq_select(isel), .i_fractional_freq_profile_select(fsel),
    .i_output_enable_low_pin(oe_n), .i_addr_select_pin(adr),
    .i_input_source_select(src), .i_profile_select(prof),
    .i_spread_pin_assigned(sp_as), .i_int_sel_pin_assigned(int_as),
    .i_frac_sel_pin_assigned(fr_as), .i_oe_pin_assigned(oe_as),
    .i_oe_pin_scope(scope), .i_oe_pin_target(tgt), .i_out_bank_map_lsb(bank0),
    .i_out_bank_map_mid(12'h000), .i_out_bank_map_msb(12'h000),
    .i_out_from_synth(from_syn), .i_out_synth_index(syn_idx), .i_out_cmos_pair(pair),
    .i_reg_spread_enable(r_sp), .i_reg_spread_center(r_ctr),
    .i_reg_spread_a_tenths(r_ta), .i_reg_spread_b_tenths(r_tb),
    .i_reg_int_select(r_isel), .i_reg_int_div_a(r_da), .i_reg_int_div_b(r_db),
    .i_reg_frac_select(r_fs), .i_reg_out_enable(r_oe), .i_reg_source_select(r_src),
    .i_factory_programmed(fact), .i_cfg_loaded(cfg), .i_out_clk(oclk),
    .o_synth_spread_on(sp_on), .o_synth_spread_center(sp_ctr),
    .o_synth_spread_tenths(sp_t), .o_synth_profile_b(prof_b), .o_int_div_value(dv),
    .o_int_div_bad(dbad), .o_out_spread(o_spr), .o_out_drive(drv),
    .o_out_gated_clk(gclk), .o_i2c_address(i2c), .o_ref_source(rsrc),
    .o_boot_profile(bprof), .o_outputs_running(run));

  task automatic wt(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  task automatic test_done;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Hang guard, well above the roughly 1060 cycles of the run
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      test_done;
    end
  end

  initial begin
    {i_rst_n, sp0, sp1, oe_n, adr, oe_as, fact, cfg} = 8'h06;
    {fsel, src, sp_as, fr_as, scope, r_sp, tgt, isel, r_isel} = '0;
    r_fs = 2'h2;
    prof = 2'h2;
    r_src = 2'h2;
    r_ctr = 2'h2;
    r_ta = {5'd31, 5'd5};
    r_tb = {5'd25, 5'd0};
    int_as = 5'h03;
    r_da = 40'hff_08_07_64_14;
    r_db = 40'h09_80_00_c8_0a;
    {bank0, from_syn, syn_idx, pair, r_oe} = {12'h007, 12'h00f, 12'h00c, 12'h030, 12'h800};
    wt(2);
    i_rst_n <= 1'b1;
    wt(30);
    #1 `CHK(run, 1'b1)
    wt(1);
    prof <= 2'h1;
    foreach (sp_tab[i]) begin
      wt(1);
      {sp_as, sp1, sp0, r_sp} <= sp_tab[i][19:14];
      wt(5);
      #1 `CHK(sp_on, sp_tab[i][13:12])
      `CHK(o_spr, sp_tab[i][11:0])
    end
    `CHK(sp_ctr, 2'h2)
    `CHK({prof_b, sp_t}, {2'h2, 5'd25, 5'd5})
    wt(1);
    fr_as <= 2'h1;
    fsel <= 2'h1;
    wt(5);
    #1 `CHK({prof_b, sp_t}, {2'h3, 5'd25, 5'd1})
    wt(1);
    fsel <= 2'h0;
    r_fs <= 2'h0;
    wt(5);
    #1 `CHK({prof_b, sp_t}, {2'h0, 5'd25, 5'd5})
    wt(1);
    isel <= 5'h01;
    r_isel <= 5'h1e;
    wt(5);
    #1 `CHK({dv, dbad}, {40'h09_80_08_64_0a, 5'h04})
    wt(1);
    isel <= 5'h02;
    r_isel <= 5'h01;
    wt(5);
    #1 `CHK({dv, dbad}, {40'hff_08_08_c8_14, 5'h04})
    for (int i = 0; i < 4; i++) begin
      wt(1);
      adr <= i[0];
      src <= i[1:0];
      wt(5);
      #1 `CHK(i2c, {6'h35, i[0]})
      `CHK(rsrc, (i == 3) ? 2'h2 : i[1:0])
    end
    foreach (oe_tab[i]) begin
      wt(1);
      {oe_as, scope, tgt, oe_n} <= oe_tab[i][19:12];
      wt(130);
      #1 `CHK(drv, oe_tab[i][11:0])
    end
    `CHK(bprof, 2'h2)
    wt(1);
    i_rst_n <= 1'b0;
    fact <= 1'b0;
    wt(2);
    i_rst_n <= 1'b1;
    wt(30);
    #1 `CHK({run, bprof}, 3'h1)
    wt(1);
    cfg <= 1'b1;
    wt(2);
    #1 `CHK(run, 1'b1)
    test_done;
  end
endmodule
`default_nettype wire
